// *** design/pcm_output_top.sv ***
// pcm output formatting, clocking and ancillary buffer with an
// ahb-lite register slave
// assumes: one clock, single word transfers, core inputs synchronous
//
// Decided for this implementation: the AHB-Lite register port.
`include "pcm_out_cfg.svh"

// Functional notes
// - lsb_first_select one shifts lsb first, zero msb first
// - pad side: zero data first, one data last; wide modes only
// - lr_polarity_select one: word select low left, high right
// - interface style zero gives i2s framing; resets to zero
// - edge select one launches on rising, zero on falling edge
// - width codes 00..11 give 16, 18, 20, 24 bit precision
// - 32 slots per word select period at 16 bits, else 64
// - routing: straight, left dup, right dup, swap; resets zero
// - at most 56 ancillary bytes per frame into 5-byte buffer
// - no refill after a full buffer until refill register written
// - post divider: core rewrites, host may write, resets 0x07
// - fixed mode holds post divider, not fine ratio; tracking follows stream
// - fixed mode default oversampling clock is 12.288 mhz
// - fine ratio is 16 bits, high byte times 256 plus low
// - fine ratio takes operational values on stream sync
// - 24-bit frame total, one per frame, cleared by both resets
// - bit clock is oversampling clock over 2*(1+divider)
module pcm_output_top
  import pcm_out_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  input  wire logic [23:0]       sample_left,
  input  wire logic [23:0]       sample_right,
  input  wire logic              sample_valid,
  output logic                   sample_taken,
  input  wire logic [7:0]        anc_byte,
  input  wire logic              anc_valid,
  output logic                   anc_taken,
  input  wire logic [15:0]       anc_bit_count,
  input  wire logic              frame_decoded,
  input  wire logic              core_rate_update,
  input  wire logic [4:0]        core_post_div,
  input  wire logic              core_sync,
  input  wire logic [15:0]       core_fine_ratio,
  output pcm_pins_s              pcm_pins,
  output pll_cfg_s               pll_cfg
);

  // ==========================================================
  // bus slave
  logic       wr_pend_q;
  logic       rd_pend_q;
  logic [7:0] idx_q;
  logic       ready_q;
  logic [31:0] rdata_q;
  logic       soft_q;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;
  logic       take;

  assign take = hsel && htrans[1] && hready && (hsize == 3'h2);
  assign wbyte = hwdata[7:0];

  function automatic logic wr_hit(input logic [7:0] idx);
    return wr_pend_q && (idx_q == idx);
  endfunction

  // reads take one wait state so a write just before is visible
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q     <= 8'h00;
      ready_q   <= 1'b1;
      rdata_q   <= 32'h0000_0000;
    end else begin
      wr_pend_q <= take && hwrite;
      rd_pend_q <= take && !hwrite;
      if (take) begin
        idx_q <= haddr[9:2];
      end
      if (take && !hwrite) begin
        ready_q <= 1'b0;
      end else if (rd_pend_q) begin
        ready_q <= 1'b1;
        rdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= wr_hit(`IDX_SOFT_RESET) && wbyte[0];
    end
  end

  // ==========================================================
  // configuration registers
  logic [7:0] cfg_q;
  route_e     route_q;
  logic [7:0] bit_div_q;
  logic       fixed_q;
  logic [4:0] post_div_q;
  logic [7:0] fine_lo_q;
  logic [7:0] fine_hi_q;
  logic [23:0] frames_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset || soft_q) begin
      cfg_q     <= `RST_CONFIG;
      route_q   <= ROUTE_STRAIGHT;
      bit_div_q <= `RST_BIT_DIV;
      fixed_q   <= 1'b0;
    end else begin
      if (wr_hit(`IDX_CONFIG)) cfg_q <= {1'b0, wbyte[6:0]};
      if (wr_hit(`IDX_ROUTING)) route_q <= route_e'(wbyte[1:0]);
      if (wr_hit(`IDX_BIT_DIV)) bit_div_q <= wbyte;
      if (wr_hit(`IDX_OSC_MODE)) fixed_q <= wbyte[0];
    end
  end

  // host write wins over a core update in the same cycle
  always_ff @(posedge mclk or posedge reset) begin
    if (reset || soft_q) begin
      post_div_q <= `RST_POST_DIV;
    end else if (wr_hit(`IDX_POST_DIV)) begin
      post_div_q <= wbyte[4:0];
    end else if (core_rate_update && !fixed_q) begin
      post_div_q <= core_post_div;
    end
  end

  // reset settings give 12.288 mhz; core_sync reloads them in fixed mode too
  always_ff @(posedge mclk or posedge reset) begin
    if (reset || soft_q) begin
      fine_lo_q <= `RST_FINE_LO;
      fine_hi_q <= `RST_FINE_HI;
    end else begin
      if (wr_hit(`IDX_FINE_LO)) begin
        fine_lo_q <= wbyte;
      end else if (core_sync) begin
        fine_lo_q <= core_fine_ratio[7:0];
      end
      if (wr_hit(`IDX_FINE_HI)) begin
        fine_hi_q <= wbyte;
      end else if (core_sync) begin
        fine_hi_q <= core_fine_ratio[15:8];
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset || soft_q) begin
      frames_q <= 24'h00_0000;
    end else if (frame_decoded) begin
      frames_q <= frames_q + 24'h00_0001;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pll_cfg <= '0;
    end else begin
      pll_cfg.fixed_mode <= fixed_q;
      pll_cfg.post_div   <= post_div_q;
      pll_cfg.fine_ratio <= {fine_hi_q, fine_lo_q};
    end
  end

  // ==========================================================
  // ancillary buffer
  logic [7:0] anc_q [`ANC_DEPTH];
  logic [2:0] fill_q;
  logic [5:0] frame_bytes_q;
  anc_state_e anc_state_q;
  logic       anc_take;

  // one byte every second cycle at most: taken is a flop
  assign anc_take = anc_valid && !anc_taken && (anc_state_q == ANC_FILL)
                    && (frame_bytes_q < 6'(`ANC_FRAME_MAX));

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      anc_state_q   <= ANC_FILL;
      fill_q        <= 3'h0;
      frame_bytes_q <= 6'h00;
      anc_taken     <= 1'b0;
      for (int i = 0; i < `ANC_DEPTH; i++) anc_q[i] <= 8'h00;
    end else if (soft_q) begin
      anc_state_q   <= ANC_FILL;
      fill_q        <= 3'h0;
      frame_bytes_q <= 6'h00;
      anc_taken     <= 1'b0;
      for (int i = 0; i < `ANC_DEPTH; i++) anc_q[i] <= 8'h00;
    end else begin
      anc_taken <= anc_take;
      if (frame_decoded) begin
        frame_bytes_q <= anc_take ? 6'h01 : 6'h00;
      end else if (anc_take) begin
        frame_bytes_q <= frame_bytes_q + 6'h01;
      end
      case (anc_state_q)
        ANC_FILL: begin
          if (anc_take) begin
            anc_q[fill_q] <= anc_byte;
            if (fill_q == 3'(`ANC_DEPTH - 1)) begin
              anc_state_q <= ANC_HOLD;
            end else begin
              fill_q <= fill_q + 3'h1;
            end
          end
        end
        ANC_HOLD: begin
          if (wr_hit(`IDX_ANC_REFILL)) begin
            anc_state_q <= ANC_FILL;
            fill_q      <= 3'h0;
          end
        end
        default: anc_state_q <= ANC_FILL;
      endcase
    end
  end

  // ==========================================================
  // read mux
  always_comb begin
    rd_byte = 8'h00;
    case (idx_q)
      `IDX_ANC_BITS_LO: rd_byte = anc_bit_count[7:0];
      `IDX_ANC_BITS_HI: rd_byte = anc_bit_count[15:8];
      `IDX_BIT_DIV:     rd_byte = bit_div_q;
      `IDX_CONFIG:      rd_byte = cfg_q;
      `IDX_ROUTING:     rd_byte = {6'h00, route_q};
      `IDX_POST_DIV:    rd_byte = {3'h0, post_div_q};
      `IDX_OSC_MODE:    rd_byte = {7'h00, fixed_q};
      `IDX_FINE_LO:     rd_byte = fine_lo_q;
      `IDX_FINE_HI:     rd_byte = fine_hi_q;
      `IDX_FRAME_LO:    rd_byte = frames_q[7:0];
      `IDX_FRAME_MID:   rd_byte = frames_q[15:8];
      `IDX_FRAME_HI:    rd_byte = frames_q[23:16];
      default: begin
        for (int i = 0; i < `ANC_DEPTH; i++) begin
          if (idx_q == `IDX_ANC_BUF0 + 8'(i)) rd_byte = anc_q[i];
        end
      end
    endcase
  end

  // ==========================================================
  // serial clocks
  logic [8:0] div_cnt_q;
  logic       sck_q;
  logic       oversampling_clock_q;
  logic       term;
  logic       launch;

  // oversampling clock is mclk / 2, bit clock derived from it
  assign term = (div_cnt_q == {bit_div_q, 1'b1});
  assign launch = term && (sck_q != cfg_q[`CFG_EDGE]);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      div_cnt_q <= 9'h000;
      sck_q     <= 1'b0;
      oversampling_clock_q    <= 1'b0;
    end else begin
      oversampling_clock_q <= ~oversampling_clock_q;
      if (term) begin
        div_cnt_q <= 9'h000;
        sck_q     <= ~sck_q;
      end else begin
        div_cnt_q <= div_cnt_q + 9'h001;
      end
    end
  end

  // ==========================================================
  // serializer
  logic [5:0]  slot_q;
  logic [5:0]  nslot;
  logic        wide;
  logic [5:0]  last;
  logic [23:0] word_l_q;
  logic [23:0] word_r_q;
  logic [23:0] word_l_d;
  logic [23:0] word_r_d;
  logic [23:0] new_l;
  logic [23:0] new_r;
  logic        frame_start;
  logic        half;
  logic [5:0]  pos;
  logic [5:0]  wlen;
  logic [5:0]  start;
  logic [5:0]  k;
  logic [5:0]  bidx;
  logic [23:0] word;
  logic        raw;
  logic        prev_q;
  logic        data_q;
  logic        ws_q;

  assign wide = (cfg_q[1:0] != 2'(WIDTH_16));
  assign last = wide ? 6'd63 : 6'd31;
  assign nslot = (slot_q == last) ? 6'd0 : slot_q + 6'd1;
  assign frame_start = launch && (nslot == 6'd0);

  always_comb begin
    case (route_q)
      ROUTE_LEFT_DUP:  begin new_l = sample_left;  new_r = sample_left;  end
      ROUTE_RIGHT_DUP: begin new_l = sample_right; new_r = sample_right; end
      ROUTE_SWAP:      begin new_l = sample_right; new_r = sample_left;  end
      default:         begin new_l = sample_left;  new_r = sample_right; end
    endcase
  end

  // without a fresh pair the last one is repeated
  assign word_l_d = (frame_start && sample_valid) ? new_l : word_l_q;
  assign word_r_d = (frame_start && sample_valid) ? new_r : word_r_q;

  always_comb begin
    case (sample_width_e'(cfg_q[1:0]))
      WIDTH_18: wlen = 6'd18;
      WIDTH_20: wlen = 6'd20;
      WIDTH_24: wlen = 6'd24;
      default:  wlen = 6'd16;
    endcase
    half  = wide ? nslot[5] : nslot[4];
    pos   = wide ? {1'b0, nslot[4:0]} : {2'b00, nslot[3:0]};
    start = (wide && cfg_q[`CFG_PAD_LEFT]) ? 6'd32 - wlen : 6'd0;
    k     = pos - start;
    bidx  = cfg_q[`CFG_LSB_FIRST] ? k : wlen - 6'd1 - k;
    word  = half ? word_r_d : word_l_d;
    raw   = 1'b0;
    if (pos >= start && k < wlen) begin
      raw = word[5'(6'(`SAMPLE_BITS) - wlen + bidx)];
    end
  end

  // i2s framing delays data one slot behind word select
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      slot_q       <= 6'd0;
      word_l_q     <= 24'h00_0000;
      word_r_q     <= 24'h00_0000;
      prev_q       <= 1'b0;
      data_q       <= 1'b0;
      ws_q         <= 1'b1;
      sample_taken <= 1'b0;
    end else begin
      sample_taken <= frame_start && sample_valid;
      if (launch) begin
        slot_q   <= nslot;
        word_l_q <= word_l_d;
        word_r_q <= word_r_d;
        prev_q   <= raw;
        data_q   <= cfg_q[`CFG_STYLE] ? raw : prev_q;
        ws_q     <= half ^ ~cfg_q[`CFG_LR_POL];
      end
    end
  end

  // ==========================================================
  // outputs
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pcm_pins <= '0;
      hresp    <= 1'b0;
    end else begin
      pcm_pins.oversampling_clock <= oversampling_clock_q;
      pcm_pins.serial_bit_clock   <= sck_q;
      pcm_pins.word_select_clock  <= ws_q;
      pcm_pins.data               <= data_q;
      hresp                       <= 1'b0;
    end
  end

  assign hreadyout = ready_q;
  assign hrdata    = rdata_q;

endmodule

// *** design/pcm_out_cfg.svh ***
// register indices, field positions, reset values and counts
// assumes: byte address on the bus is four times the register index
`ifndef PCM_OUT_CFG_SVH
`define PCM_OUT_CFG_SVH

// ==========================================================
// register indices
`define IDX_ANC_BITS_LO   8'h41
`define IDX_ANC_BITS_HI   8'h42
`define IDX_BIT_DIV       8'h54
`define IDX_CONFIG        8'h55
`define IDX_ROUTING       8'h56
`define IDX_ANC_BUF0      8'h59
`define IDX_ANC_REFILL    8'h5E
`define IDX_POST_DIV      8'h61
`define IDX_OSC_MODE      8'h63
`define IDX_FINE_LO       8'h64
`define IDX_FINE_HI       8'h65
`define IDX_FRAME_LO      8'h67
`define IDX_FRAME_MID     8'h68
`define IDX_FRAME_HI      8'h69
`define IDX_SOFT_RESET    8'h10

// ==========================================================
// reset values
`define RST_CONFIG        8'h21
`define RST_ROUTING       2'h0
`define RST_BIT_DIV       8'h03
`define RST_POST_DIV      5'h07
`define RST_FINE_LO       8'h46
`define RST_FINE_HI       8'h5B

// ==========================================================
// config field positions
`define CFG_LSB_FIRST     6
`define CFG_PAD_LEFT      5
`define CFG_LR_POL        4
`define CFG_STYLE         3
`define CFG_EDGE          2
`define CFG_WIDTH_HI      1
`define CFG_WIDTH_LO      0

// ==========================================================
// counts
`define ANC_DEPTH         5
`define ANC_FRAME_MAX     56
`define SAMPLE_BITS       24

`endif

// *** design/pcm_out_pkg.sv ***
// types shared by the pcm output block
// assumes: constants come from pcm_out_cfg.svh
package pcm_out_pkg;

  // ==========================================================
  // modes and states
  typedef enum logic [1:0] {
    WIDTH_16,
    WIDTH_18,
    WIDTH_20,
    WIDTH_24
  } sample_width_e;

  typedef enum logic [1:0] {
    ROUTE_STRAIGHT,
    ROUTE_LEFT_DUP,
    ROUTE_RIGHT_DUP,
    ROUTE_SWAP
  } route_e;

  typedef enum logic {
    ANC_FILL,
    ANC_HOLD
  } anc_state_e;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       fixed_mode;
    logic [4:0] post_div;
    logic [15:0] fine_ratio;
  } pll_cfg_s;

  typedef struct packed {
    logic oversampling_clock;
    logic serial_bit_clock;
    logic word_select_clock;
    logic data;
  } pcm_pins_s;

endpackage

// *** sim/pcm_output_checker_assertions.sv ***
// port checks for the pcm output block
// assumes: bound to pcm_output_top, hready fed back from hreadyout
module pcm_output_checker
  import pcm_out_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic              hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [2:0]        hsize,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic [31:0]       hrdata,
  input wire logic              hresp,
  input wire logic              sample_taken,
  input wire logic              anc_valid,
  input wire logic              anc_taken,
  input wire logic              core_rate_update,
  input wire logic [4:0]        core_post_div,
  input wire pcm_pins_s         pcm_pins,
  input wire pll_cfg_s          pll_cfg
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  logic go;
  assign go = hsel && htrans[1] && hready && hsize == 3'h2;

  // ==========================================================
  // bus
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("bad response");
  property p_rd_wait; go && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait");
  property p_wr_zero; go && hwrite |=> hreadyout; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write wait");
  property p_rd_hi; go && !hwrite |=> ##1 hrdata[31:8] == 24'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("read upper bits");

  // ==========================================================
  // core ports
  property p_smp; sample_taken |=> !sample_taken [*8]; endproperty
  a_smp: assert property (p_smp) else $error("sample rate");
  property p_anc_one; anc_taken |=> !anc_taken; endproperty
  a_anc_one: assert property (p_anc_one) else $error("anc pulse");
  property p_anc_src; anc_taken |-> $past(anc_valid); endproperty
  a_anc_src: assert property (p_anc_src) else $error("anc cause");
  // host traffic excluded: a host write may win over the core
  property p_div;
    core_rate_update && !pll_cfg.fixed_mode && !hsel && !$past(hsel)
      |-> ##2 pll_cfg.post_div == $past(core_post_div, 2);
  endproperty
  a_div: assert property (p_div) else $error("post div load");
  property p_fix;
    pll_cfg.fixed_mode && !hsel && !$past(hsel)
      |=> $stable(pll_cfg.post_div);
  endproperty
  a_fix: assert property (p_fix) else $error("fixed mode");
  // first edge after release still shows the reset level
  property p_osc;
    !$past(reset) |=> pcm_pins.oversampling_clock
      != $past(pcm_pins.oversampling_clock);
  endproperty
  a_osc: assert property (p_osc) else $error("osc clock");

  c_rd: cover property (go && !hwrite);
  c_anc: cover property (anc_taken);
  c_smp: cover property (sample_taken);
  c_div: cover property (core_rate_update);
endmodule

bind pcm_output_top pcm_output_checker #(.ADDR_W(ADDR_W)) chk_u (
  .mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .sample_taken(sample_taken), .anc_valid(anc_valid),
  .anc_taken(anc_taken), .core_rate_update(core_rate_update),
  .core_post_div(core_post_div), .pcm_pins(pcm_pins),
  .pll_cfg(pll_cfg));

// *** sim/dac_model.sv ***
// serial dac receiving the pcm pins
// assumes: pins are mclk flops, so mclk sampling sees every edge
module dac_model
  import pcm_out_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      reset,
  input  wire pcm_pins_s pins,
  input  wire logic      samp_fall,
  output logic [31:0]    word_lo,
  output logic [31:0]    word_hi,
  output logic [6:0]     bits_lo,
  output logic [6:0]     bits_hi
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        sck_q;
  logic        ws_q;
  logic [31:0] sh_q;
  logic [6:0]  cnt_q;
  logic        hit;

  // ==========================================================
  // capture on the edge opposite to launch
  assign hit = pins.serial_bit_clock != sck_q
    && pins.serial_bit_clock == !samp_fall;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sck_q <= 1'b0;
      ws_q <= 1'b0;
      sh_q <= 32'h0;
      cnt_q <= 7'h0;
      word_lo <= 32'h0;
      word_hi <= 32'h0;
      bits_lo <= 7'h0;
      bits_hi <= 7'h0;
    end else begin
      sck_q <= pins.serial_bit_clock;
      if (hit) begin
        ws_q <= pins.word_select_clock;
        // first half after reset may be partial: caller skips it
        if (pins.word_select_clock != ws_q && cnt_q != 7'h0) begin
          if (ws_q) begin
            word_hi <= sh_q;
            bits_hi <= cnt_q;
          end else begin
            word_lo <= sh_q;
            bits_lo <= cnt_q;
          end
          sh_q <= {31'h0, pins.data};
          cnt_q <= 7'h1;
        end else begin
          sh_q <= {sh_q[30:0], pins.data};
          cnt_q <= cnt_q + 7'h1;
        end
      end
    end
  end
endmodule

// *** sim/pcm_output_format_and_clocking_tb.sv ***
// self-checking bench for pcm_output_top
// assumes: dac_model on the pins, bench is the only bus master
module pcm_output_format_and_clocking_tb
  import pcm_out_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        mclk, reset, hsel, hwrite, hreadyout, hresp, tk, fall;
  logic        sample_valid, sample_taken, anc_valid, anc_taken;
  logic        frame_decoded, core_rate_update, core_sync;
  logic [9:0]  haddr;
  logic [1:0]  htrans, kk;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, q, d, lw, rw, word_lo, word_hi;
  logic [23:0] sl, sr;
  logic [7:0]  anc_byte, cfg;
  logic [15:0] anc_bit_count, core_fine_ratio;
  logic [4:0]  core_post_div;
  logic [6:0]  bits_lo, bits_hi;
  pcm_pins_s   pcm_pins;
  pll_cfg_s    pll_cfg;
  int          err_total, checked, cyc, seed, w, n, sl_n;
  logic [7:0]  ix [0:12] = '{8'h55, 8'h56, 8'h54, 8'h59, 8'h5D, 8'h61,
    8'h63, 8'h64, 8'h65, 8'h67, 8'h68, 8'h69, 8'h7F};
  logic [7:0]  ev [0:12] = '{8'h21, 8'h00, 8'h03, 8'h00, 8'h00, 8'h07,
    8'h00, 8'h46, 8'h5B, 8'h00, 8'h00, 8'h00, 8'h00};

  always #25 mclk = ~mclk;

  pcm_output_top dut_u (.mclk(mclk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .sample_left(sl),
    .sample_right(sr), .sample_valid(sample_valid),
    .sample_taken(sample_taken), .anc_byte(anc_byte),
    .anc_valid(anc_valid), .anc_taken(anc_taken),
    .anc_bit_count(anc_bit_count), .frame_decoded(frame_decoded),
    .core_rate_update(core_rate_update), .core_post_div(core_post_div),
    .core_sync(core_sync), .core_fine_ratio(core_fine_ratio),
    .pcm_pins(pcm_pins), .pll_cfg(pll_cfg));

  dac_model dac_u (.mclk(mclk), .reset(reset), .pins(pcm_pins),
    .samp_fall(fall), .word_lo(word_lo), .word_hi(word_hi),
    .bits_lo(bits_lo), .bits_hi(bits_hi));

  // ==========================================================
  // helpers
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(logic wr, logic [7:0] idx, logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {idx, 2'h0};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic rd(logic [7:0] idx, logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    chk($sformatf("reg %h", idx), e, q);
  endtask

  task automatic push(logic [7:0] b);
    @(posedge mclk);
    anc_byte <= b;
    anc_valid <= 1'b1;
    tk = 1'b0;
    for (int i = 0; i < 20 && !tk; i++) begin
      @(posedge mclk);
      tk = anc_taken === 1'b1;
    end
    anc_valid <= 1'b0;
  endtask

  task automatic pulse_frame();
    @(posedge mclk);
    frame_decoded <= 1'b1;
    @(posedge mclk);
    frame_decoded <= 1'b0;
  endtask

  function automatic logic [31:0] exp_v(logic [23:0] s, int wd, logic l);
    logic [31:0] v;
    logic [31:0] r;
    v = 32'(s >> (24 - wd));
    r = 32'h0;
    for (int i = 0; i < wd; i++) r[wd-1-i] = v[i];
    return l ? r : v;
  endfunction

  function automatic logic [31:0] got_v(logic [31:0] g, int s, int wd,
                                        logic pad);
    return pad ? g & ((32'h1 << wd) - 32'h1) : g >> (s - wd);
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // long serial waits dominate the run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      stop_test();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    {mclk, hsel, hwrite, htrans, haddr, hwdata, anc_valid, anc_byte} = 0;
    {frame_decoded, core_rate_update, core_sync, fall} = 0;
    {core_post_div, core_fine_ratio, anc_bit_count, sl, sr} = 0;
    {err_total, checked, cyc} = 0;
    hsize = 3'h2;
    sample_valid = 1'b1;
    reset = 1'b1;
    seed = 32'h902EE8A7;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("pll", {10'h0, 22'h075B46}, 32'(pll_cfg));
    for (int i = 0; i < 13; i++) rd(ix[i], {24'h0, ev[i]});
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      bus(1'b1, 8'h55, d);
      rd(8'h55, d & 32'h7F);
      bus(1'b1, 8'h56, d);
      rd(8'h56, d & 32'h3);
      bus(1'b1, 8'h61, d);
      rd(8'h61, d & 32'h1F);
    end
    bus(1'b1, 8'h67, 32'hFF);
    rd(8'h67, 32'h0);
    d = $random(seed);
    anc_bit_count <= d[15:0];
    rd(8'h41, {24'h0, d[7:0]});
    rd(8'h42, {24'h0, d[15:8]});
    $display("test access done");
    n = ($random(seed) & 15) + 1;
    repeat (n) pulse_frame();
    rd(8'h67, 32'(n));
    rd(8'h68, 32'h0);
    for (int i = 0; i < 5; i++) push(8'hA0 + i[7:0]);
    push(8'hAA);
    chk("anc held", 32'h0, {31'h0, tk});
    for (int i = 0; i < 5; i++) rd(8'h59 + i[7:0], 32'hA0 + i);
    for (int i = 5; i < 56; i++) begin
      if (i % 5 == 0) bus(1'b1, 8'h5E, 32'h0);
      push(i[7:0]);
      chk("anc taken", 32'h1, {31'h0, tk});
    end
    bus(1'b1, 8'h5E, 32'h0);
    push(8'h77);
    chk("anc frame cap", 32'h0, {31'h0, tk});
    pulse_frame();
    push(8'h78);
    chk("anc new frame", 32'h1, {31'h0, tk});
    $display("test ancillary done");
    d = $random(seed);
    core_post_div <= d[4:0];
    core_fine_ratio <= d[31:16];
    @(posedge mclk);
    core_rate_update <= 1'b1;
    core_sync <= 1'b1;
    @(posedge mclk);
    core_rate_update <= 1'b0;
    core_sync <= 1'b0;
    rd(8'h61, {27'h0, d[4:0]});
    rd(8'h64, {24'h0, d[23:16]});
    rd(8'h65, {24'h0, d[31:24]});
    chk("pll fine", {16'h0, d[31:16]}, {16'h0, pll_cfg.fine_ratio});
    bus(1'b1, 8'h63, 32'h1);
    core_post_div <= ~d[4:0];
    @(posedge mclk);
    core_rate_update <= 1'b1;
    @(posedge mclk);
    core_rate_update <= 1'b0;
    rd(8'h61, {27'h0, d[4:0]});
    bus(1'b1, 8'h63, 32'h0);
    $display("test clock setup done");
    // divider left at reset 3: 256x at 16 bits, 512x when wide
    for (int k = 0; k < 4; k++) begin
      kk = k[1:0];
      w = (k == 3) ? 24 : 16 + 2 * k;
      sl_n = (w == 16) ? 16 : 32;
      cfg = {1'b0, kk[0], kk == 2'h2, kk != 2'h3, kk != 2'h1, kk[1], kk};
      // i2s framing on 18 bits: data one slot late, behind a pad slot
      n = cfg[3] ? sl_n : sl_n - 1;
      sl <= 24'($random(seed));
      sr <= 24'($random(seed));
      fall <= kk[1];
      bus(1'b1, 8'h55, {24'h0, cfg});
      bus(1'b1, 8'h56, {30'h0, kk});
      repeat (3200) @(posedge mclk);
      lw = cfg[4] ? word_lo : word_hi;
      rw = cfg[4] ? word_hi : word_lo;
      chk("left", exp_v(kk[1] ? sr : sl, w, kk[0]),
          got_v(lw, n, w, cfg[5]));
      chk("right", exp_v(kk[0] ? sl : sr, w, kk[0]),
          got_v(rw, n, w, cfg[5]));
      chk("slots lo", 32'(sl_n), {25'h0, bits_lo});
      chk("slots hi", 32'(sl_n), {25'h0, bits_hi});
    end
    $display("test serial done");
    bus(1'b1, 8'h10, 32'h1);
    rd(8'h55, 32'h21);
    rd(8'h56, 32'h0);
    rd(8'h67, 32'h0);
    $display("test soft reset done");
    stop_test();
  end
endmodule
